/* verilog/endian_swap_defines.svh */
// Purpose: Constants for the endian steering block
// Assumes: 32-bit DSP side words, 16-bit host port
// Notes: Included by bare name
`ifndef ENDIAN_SWAP_DEFINES_SVH
`define ENDIAN_SWAP_DEFINES_SVH
// Access width codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
// Host port swap defaults after reset
`define HP_BYTE_SWAP_RST 1'h0
`define HP_HALF_SWAP_RST 1'h1
// Memory path swap default after reset
`define MEM_SWAP_EN_RST 1'h0
`endif

/* verilog/endian_swap_pkg.sv */
// Purpose: Types for the endian steering block
// Assumes: Nothing beyond the defines header
// Notes: Host port sequencing states
package endian_swap_pkg;
   typedef enum logic [1:0] {HP_IDLE, HP_FIRST, HP_SECOND} hp_state_e;
   typedef logic [1:0] size_t;
endpackage

/* verilog/byte_steer.sv */
// Purpose: Combinational repack of one 32-bit word by width and mode
// Assumes: Right-justified narrow data
// Notes: Same function serves both directions
`timescale 1ns/100ps
`default_nettype none
`include "endian_swap_defines.svh"
module byte_steer (
   input wire logic [31:0] data_i,
   input wire logic [1:0] size_i,
   input wire logic byte_swap_i,
   input wire logic half_swap_i,
   output logic [31:0] data_o
);
   always_comb begin
      data_o = data_i;
      if (size_i == `SIZE_WORD) begin
         if (half_swap_i) begin
            data_o = {data_i[15:0], data_i[31:16]};
         end else if (byte_swap_i) begin
            data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]};
         end
      end else if (size_i == `SIZE_HALF) begin
         data_o = {16'h0000, byte_swap_i ? {data_i[7:0], data_i[15:8]} : data_i[15:0]};
      end else begin
         data_o = {24'h00_0000, data_i[7:0]};
      end
   end
endmodule
`default_nettype wire

/* verilog/endian_swap_steering.sv */
// Purpose: Endian steering on the memory path and the host port path
// Assumes: One clock; swap enables sampled when an access is taken
// Notes: Narrow data is right-justified on every path
// Operation
// - Swap words between big and little endian
// - Convert memory path and host port path
// - Disabled swapping passes data unchanged
// - Aligned word byte swap fully reverses bytes
// - Odd or halfword-mode write swaps halves
// - Odd or halfword-mode read swaps halves
// - Halfword format carries bytes 1,0,3,2
// - Byte and halfword stay right-justified
// - Memory path swapping off after reset; here mem_swap_en_i is an input used directly, with no reset value
// - Decode width first then repack
// - Host port separate memory/register controls
// - Host word split into two halves
// - Host reset: byte swap off, half on
`timescale 1ns/100ps
`default_nettype none
`include "endian_swap_defines.svh"
module endian_swap_steering (
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Memory path
   input wire logic mem_swap_en_i,
   input wire logic mem_byte_mode_i,
   input wire logic mem_req_i,
   input wire logic mem_write_i,
   input wire logic [1:0] mem_size_i,
   input wire logic mem_addr1_i,
   input wire logic [31:0] mem_dsp_wdata_i,
   input wire logic [31:0] mem_sys_rdata_i,
   output logic mem_valid_o,
   output logic [31:0] mem_sys_wdata_o,
   output logic [31:0] mem_dsp_rdata_o,
   // Host port path
   input wire logic hp_cfg_load_i,
   input wire logic hp_mem_byte_swap_i,
   input wire logic hp_mem_half_swap_i,
   input wire logic hp_reg_byte_swap_i,
   input wire logic hp_reg_half_swap_i,
   input wire logic hp_req_i,
   input wire logic hp_is_mem_i,
   input wire logic [1:0] hp_size_i,
   input wire logic [31:0] hp_dsp_data_i,
   output logic hp_busy_o,
   output logic hp_valid_o,
   output logic [15:0] hp_data_o
);
   // -----------------------------
   // Memory path
   // -----------------------------
   logic [31:0] mem_w_steer, mem_r_steer;
   logic mem_half;
   logic mem_byte_en;
   logic mem_valid_q, mem_valid_d;
   logic [31:0] mem_wdata_q, mem_wdata_d, mem_rdata_q, mem_rdata_d;

   // Odd halfword start or halfword mode picks half exchange
   assign mem_half = mem_swap_en_i & (mem_addr1_i | ~mem_byte_mode_i);
   // Half exchange outranks byte reverse inside the repack, so halfword accesses keep their byte swap
   // Nothing swaps until mem_swap_en_i is raised; the enable is an input and gets no reset value here
   assign mem_byte_en = mem_swap_en_i;

   // Each repack is its own inverse, so one copy per direction suffices
   byte_steer u_mem_wr (
      .data_i(mem_dsp_wdata_i),
      .size_i(mem_size_i),
      .byte_swap_i(mem_byte_en),
      .half_swap_i(mem_half),
      .data_o(mem_w_steer)
   );
   byte_steer u_mem_rd (
      .data_i(mem_sys_rdata_i),
      .size_i(mem_size_i),
      .byte_swap_i(mem_byte_en),
      .half_swap_i(mem_half),
      .data_o(mem_r_steer)
   );

   always_comb begin
      mem_valid_d = mem_req_i;
      mem_wdata_d = mem_wdata_q;
      mem_rdata_d = mem_rdata_q;
      if (mem_req_i) begin
         if (mem_write_i) begin
            mem_wdata_d = mem_w_steer;
         end else begin
            mem_rdata_d = mem_r_steer;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mem_valid_q <= 1'b0;
         mem_wdata_q <= 32'h0000_0000;
         mem_rdata_q <= 32'h0000_0000;
      end else begin
         mem_valid_q <= mem_valid_d;
         mem_wdata_q <= mem_wdata_d;
         mem_rdata_q <= mem_rdata_d;
      end
   end
   assign mem_valid_o = mem_valid_q;
   assign mem_sys_wdata_o = mem_wdata_q;
   assign mem_dsp_rdata_o = mem_rdata_q;

   // -----------------------------
   // Host port configuration
   // -----------------------------
   logic hp_mb_q, hp_mb_d, hp_mh_q, hp_mh_d, hp_rb_q, hp_rb_d, hp_rh_q, hp_rh_d;

   always_comb begin
      hp_mb_d = hp_mb_q;
      hp_mh_d = hp_mh_q;
      hp_rb_d = hp_rb_q;
      hp_rh_d = hp_rh_q;
      if (hp_cfg_load_i) begin
         hp_mb_d = hp_mem_byte_swap_i;
         hp_mh_d = hp_mem_half_swap_i;
         hp_rb_d = hp_reg_byte_swap_i;
         hp_rh_d = hp_reg_half_swap_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hp_mb_q <= `HP_BYTE_SWAP_RST;
         hp_rb_q <= `HP_BYTE_SWAP_RST;
         hp_mh_q <= `HP_HALF_SWAP_RST;
         hp_rh_q <= `HP_HALF_SWAP_RST;
      end else begin
         hp_mb_q <= hp_mb_d;
         hp_mh_q <= hp_mh_d;
         hp_rb_q <= hp_rb_d;
         hp_rh_q <= hp_rh_d;
      end
   end

   // -----------------------------
   // Host port sequencer
   // -----------------------------
   endian_swap_pkg::hp_state_e hp_state_q, hp_state_d;
   logic [31:0] hp_steer, hp_word_q, hp_word_d;
   logic hp_sel_byte, hp_sel_half;
   logic hp_valid_q, hp_valid_d;
   logic [15:0] hp_out_q, hp_out_d;

   assign hp_sel_byte = hp_is_mem_i ? hp_mb_q : hp_rb_q;
   assign hp_sel_half = hp_is_mem_i ? hp_mh_q : hp_rh_q;

   byte_steer u_hp (
      .data_i(hp_dsp_data_i),
      .size_i(hp_size_i),
      .byte_swap_i(hp_sel_byte),
      .half_swap_i(hp_sel_half),
      .data_o(hp_steer)
   );

   always_comb begin
      hp_state_d = hp_state_q;
      hp_word_d = hp_word_q;
      hp_valid_d = 1'b0;
      hp_out_d = hp_out_q;
      case (hp_state_q)
         endian_swap_pkg::HP_IDLE: begin
            if (hp_req_i) begin
               // Steered word is frozen here so later control changes cannot tear it
               hp_word_d = hp_steer;
               hp_valid_d = 1'b1;
               hp_out_d = hp_steer[15:0];
               if (hp_size_i == `SIZE_WORD) begin
                  hp_state_d = endian_swap_pkg::HP_SECOND;
               end
            end
         end
         endian_swap_pkg::HP_SECOND: begin
            hp_valid_d = 1'b1;
            hp_out_d = hp_word_q[31:16];
            hp_state_d = endian_swap_pkg::HP_IDLE;
         end
         default: begin
            hp_state_d = endian_swap_pkg::HP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hp_state_q <= endian_swap_pkg::HP_IDLE;
         hp_word_q <= 32'h0000_0000;
         hp_valid_q <= 1'b0;
         hp_out_q <= 16'h0000;
      end else begin
         hp_state_q <= hp_state_d;
         hp_word_q <= hp_word_d;
         hp_valid_q <= hp_valid_d;
         hp_out_q <= hp_out_d;
      end
   end
   assign hp_busy_o = (hp_state_q != endian_swap_pkg::HP_IDLE);
   assign hp_valid_o = hp_valid_q;
   assign hp_data_o = hp_out_q;

   // -----------------------------
   // Host port checks
   // -----------------------------
   sequence hp_word_take_s;
      hp_req_i && !hp_busy_o && hp_size_i == `SIZE_WORD;
   endsequence
   sequence hp_two_beats_s;
      (hp_valid_o && hp_busy_o) ##1 (hp_valid_o && !hp_busy_o);
   endsequence
   sequence hp_byte_take_s;
      hp_req_i && !hp_busy_o && hp_size_i == `SIZE_BYTE;
   endsequence

   hp_split_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_word_take_s |=> hp_two_beats_s) else $error("host word not split in two");
   hp_upper_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_word_take_s |=> ##1 hp_data_o == $past(hp_steer[31:16], 2))
      else $error("host upper half wrong");
   hp_narrow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_req_i && !hp_busy_o && hp_size_i != `SIZE_WORD |=> hp_valid_o && !hp_busy_o)
      else $error("host narrow access not single");
   hp_refuse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_busy_o |=> !hp_busy_o) else $error("host request taken while busy");
   hp_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !hp_req_i && !hp_busy_o |=> !hp_valid_o) else $error("host half without request");
   hp_byte_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_byte_take_s |=> hp_data_o == {8'h00, $past(hp_dsp_data_i[7:0])})
      else $error("host byte not right-justified");
   // Half exchange wins over byte reverse whatever the region's byte bit says
   hp_half_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_word_take_s ##0 (hp_is_mem_i ? hp_mh_q : hp_rh_q) |=> hp_data_o == $past(hp_dsp_data_i[31:16]))
      else $error("host region half swap wrong");
   hp_pass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_word_take_s ##0 !(hp_is_mem_i ? (hp_mh_q | hp_mb_q) : (hp_rh_q | hp_rb_q))
      |=> hp_data_o == $past(hp_dsp_data_i[15:0]) ##1 hp_data_o == $past(hp_dsp_data_i[31:16], 2))
      else $error("host bypass altered data");
   hp_cfg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hp_cfg_load_i |=> hp_mb_q == $past(hp_mem_byte_swap_i) && hp_mh_q == $past(hp_mem_half_swap_i)
      && hp_rb_q == $past(hp_reg_byte_swap_i) && hp_rh_q == $past(hp_reg_half_swap_i))
      else $error("host swap controls not loaded");
   hp_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !hp_cfg_load_i |=> $stable(hp_mb_q) && $stable(hp_mh_q) && $stable(hp_rb_q) && $stable(hp_rh_q))
      else $error("host swap controls moved without load");

   // -----------------------------
   // Memory path checks
   // -----------------------------
   sequence mem_wr_word_s;
      mem_req_i && mem_write_i && mem_size_i == `SIZE_WORD;
   endsequence
   sequence mem_rd_word_s;
      mem_req_i && !mem_write_i && mem_size_i == `SIZE_WORD;
   endsequence

   mem_byte_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i && mem_write_i && mem_size_i == `SIZE_WORD && mem_swap_en_i && mem_byte_mode_i && !mem_addr1_i
      |=> mem_sys_wdata_o[31:24] == $past(mem_dsp_wdata_i[7:0])) else $error("byte reverse wrong");
   mem_halfw_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i && mem_write_i && mem_size_i == `SIZE_WORD && mem_swap_en_i && (mem_addr1_i || !mem_byte_mode_i)
      |=> mem_sys_wdata_o == {$past(mem_dsp_wdata_i[15:0]), $past(mem_dsp_wdata_i[31:16])})
      else $error("write half swap wrong");
   mem_halfr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i && !mem_write_i && mem_size_i == `SIZE_WORD && mem_swap_en_i && (mem_addr1_i || !mem_byte_mode_i)
      |=> mem_dsp_rdata_o[31:24] == $past(mem_sys_rdata_i[15:8])) else $error("read half swap wrong");
   mem_bypass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i && !mem_write_i && !mem_swap_en_i && mem_size_i == `SIZE_WORD
      |=> mem_dsp_rdata_o == $past(mem_sys_rdata_i)) else $error("bypass altered data");
   mem_right_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i && !mem_write_i && mem_size_i == `SIZE_BYTE
      |=> mem_dsp_rdata_o[31:8] == 24'h00_0000) else $error("byte not right-justified");
   mem_valid_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i |=> mem_valid_o) else $error("memory access not answered");
   mem_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !mem_req_i |=> !mem_valid_o) else $error("memory answer without access");
   mem_wpass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_wr_word_s ##0 !mem_swap_en_i |=> mem_sys_wdata_o == $past(mem_dsp_wdata_i))
      else $error("write bypass altered data");
   mem_rbyte_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_rd_word_s ##0 (mem_swap_en_i && mem_byte_mode_i && !mem_addr1_i)
      |=> mem_dsp_rdata_o == {$past(mem_sys_rdata_i[7:0]), $past(mem_sys_rdata_i[15:8]),
      $past(mem_sys_rdata_i[23:16]), $past(mem_sys_rdata_i[31:24])}) else $error("read byte reverse wrong");
   mem_rswap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_rd_word_s ##0 (mem_swap_en_i && (mem_addr1_i || !mem_byte_mode_i))
      |=> mem_dsp_rdata_o == {$past(mem_sys_rdata_i[15:0]), $past(mem_sys_rdata_i[31:16])})
      else $error("halfword format wrong");
   mem_hjust_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i && mem_write_i && mem_size_i == `SIZE_HALF && mem_swap_en_i
      |=> mem_sys_wdata_o == {16'h0000, $past(mem_dsp_wdata_i[7:0]), $past(mem_dsp_wdata_i[15:8])})
      else $error("write halfword not right-justified");
   mem_wjust_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mem_req_i && mem_write_i && mem_size_i == `SIZE_BYTE |=> mem_sys_wdata_o[31:8] == 24'h00_0000)
      else $error("write byte not right-justified");
   mem_whold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(mem_req_i && mem_write_i) |=> $stable(mem_sys_wdata_o))
      else $error("write data moved without write");
   mem_rhold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(mem_req_i && !mem_write_i) |=> $stable(mem_dsp_rdata_o))
      else $error("read data moved without read");
endmodule
`default_nettype wire

/* verif/sys_mem_model.sv */
// Purpose: One-word system memory behind the memory path
// Assumes: Read data is wanted in the request cycle
// Notes: Read data is inverted outside read cycles
`timescale 1ns/100ps
`default_nettype none
module sys_mem_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic req_i,
   input wire logic write_i,
   input wire logic valid_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o
);
   logic [31:0] word_q;
   logic wr_q;
   // Inverted when idle so stale data never looks like a good answer
   assign rdata_o = (req_i && !write_i) ? word_q : ~word_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         word_q <= 32'h0000_0000;
         wr_q <= 1'b0;
      end else begin
         if (req_i) begin
            wr_q <= write_i;
         end
         if (valid_i && wr_q) begin
            word_q <= wdata_i;
         end
      end
   end
endmodule
`default_nettype wire

/* verif/endian_swap_steering_test.sv */
// Purpose: Self-checking bench for the endian steering block
// Assumes: Inputs driven on the rising edge
// Notes: Expected words computed locally from widths and modes
`timescale 1ns/100ps
`default_nettype none
`include "endian_swap_defines.svh"
module endian_swap_steering_test;
   logic clk_i, reset_n_i, mem_swap_en_i, mem_byte_mode_i, mem_req_i, mem_write_i, mem_addr1_i;
   logic [1:0] mem_size_i, hp_size_i;
   logic [31:0] mem_dsp_wdata_i, mem_sys_rdata_i, mem_sys_wdata_o, mem_dsp_rdata_o, hp_dsp_data_i;
   logic mem_valid_o, hp_cfg_load_i, hp_mem_byte_swap_i, hp_mem_half_swap_i, hp_reg_byte_swap_i;
   logic hp_reg_half_swap_i, hp_req_i, hp_is_mem_i, hp_busy_o, hp_valid_o;
   logic [15:0] hp_data_o;
   logic [31:0] w;
   int n_errors = 0;
   int n_checks = 0;
   endian_swap_steering dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .mem_swap_en_i(mem_swap_en_i),
      .mem_byte_mode_i(mem_byte_mode_i), .mem_req_i(mem_req_i), .mem_write_i(mem_write_i),
      .mem_size_i(mem_size_i), .mem_addr1_i(mem_addr1_i), .mem_dsp_wdata_i(mem_dsp_wdata_i),
      .mem_sys_rdata_i(mem_sys_rdata_i), .mem_valid_o(mem_valid_o), .mem_sys_wdata_o(mem_sys_wdata_o),
      .mem_dsp_rdata_o(mem_dsp_rdata_o), .hp_cfg_load_i(hp_cfg_load_i),
      .hp_mem_byte_swap_i(hp_mem_byte_swap_i), .hp_mem_half_swap_i(hp_mem_half_swap_i),
      .hp_reg_byte_swap_i(hp_reg_byte_swap_i), .hp_reg_half_swap_i(hp_reg_half_swap_i),
      .hp_req_i(hp_req_i), .hp_is_mem_i(hp_is_mem_i), .hp_size_i(hp_size_i),
      .hp_dsp_data_i(hp_dsp_data_i), .hp_busy_o(hp_busy_o), .hp_valid_o(hp_valid_o), .hp_data_o(hp_data_o));
   sys_mem_model mem_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(mem_req_i), .write_i(mem_write_i),
      .valid_i(mem_valid_o), .wdata_i(mem_sys_wdata_o), .rdata_o(mem_sys_rdata_i));
   function automatic logic [31:0] steer(input logic [31:0] d, input logic [1:0] sz, input logic bs,
      input logic hs);
      if (sz == `SIZE_WORD) return hs ? {d[15:0], d[31:16]} : bs ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      if (sz == `SIZE_HALF) return bs ? {16'h0000, d[7:0], d[15:8]} : {16'h0000, d[15:0]};
      return {24'h00_0000, d[7:0]};
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task mem_op(input logic wr, input logic [1:0] sz, input logic a1, input logic en, input logic md,
      input logic [31:0] d, input logic [31:0] exp);
      @(posedge clk_i);
      mem_req_i <= 1'b1;
      mem_write_i <= wr;
      mem_size_i <= sz;
      mem_addr1_i <= a1;
      mem_swap_en_i <= en;
      mem_byte_mode_i <= md;
      mem_dsp_wdata_i <= d;
      @(posedge clk_i);
      mem_req_i <= 1'b0;
      #1;
      check(mem_valid_o, 32'h0000_0001);
      check(wr ? mem_sys_wdata_o : mem_dsp_rdata_o, exp);
   endtask
   task hp_op(input logic is_mem, input logic [1:0] sz, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk_i);
      hp_req_i <= 1'b1;
      hp_is_mem_i <= is_mem;
      hp_size_i <= sz;
      hp_dsp_data_i <= d;
      @(posedge clk_i);
      // A word keeps requesting while busy; that request must be dropped
      hp_req_i <= (sz == `SIZE_WORD);
      // New data while busy must not reach the upper half
      hp_dsp_data_i <= ~d;
      #1;
      check(hp_valid_o, 32'h0000_0001);
      check(hp_data_o, e[15:0]);
      check(hp_busy_o, sz == `SIZE_WORD);
      if (sz == `SIZE_WORD) begin
         @(posedge clk_i);
         hp_req_i <= 1'b0;
         #1;
         check(hp_data_o, e[31:16]);
         check(hp_busy_o, 32'h0000_0000);
      end
      @(posedge clk_i);
      #1;
      check(hp_valid_o, 32'h0000_0000);
   endtask
   task hp_load(input logic mb, input logic mh, input logic rb, input logic rh);
      @(posedge clk_i);
      {hp_cfg_load_i, hp_mem_byte_swap_i, hp_mem_half_swap_i, hp_reg_byte_swap_i, hp_reg_half_swap_i} <=
         {1'b1, mb, mh, rb, rh};
      @(posedge clk_i);
      // Inputs flip after the load and must be ignored
      {hp_cfg_load_i, hp_mem_byte_swap_i, hp_mem_half_swap_i, hp_reg_byte_swap_i, hp_reg_half_swap_i} <=
         {1'b0, ~mb, ~mh, ~rb, ~rh};
   endtask
   task mem_sweep;
      logic [1:0] sz;
      logic a1, en, md, hs;
      for (int i = 0; i < 24; i++) begin
         sz = 2'(i % 3);
         a1 = 1'((i / 3) % 2);
         en = 1'(i / 12);
         md = 1'((i / 6) % 2);
         hs = en & (a1 | ~md);
         w = steer(32'hAABB_CCDD ^ i, sz, en, hs);
         mem_op(1'b1, sz, a1, en, md, 32'hAABB_CCDD ^ i, w);
         mem_op(1'b0, sz, a1, en, md, 32'h0000_0000, steer(w, sz, en, hs));
      end
   endtask
   task mem_known;
      mem_op(1'b1, `SIZE_WORD, 1'b0, 1'b1, 1'b1, 32'hAABB_CCDD, 32'hDDCC_BBAA);
      mem_op(1'b0, `SIZE_WORD, 1'b1, 1'b1, 1'b1, 32'h0000_0000, 32'hBBAA_DDCC);
      mem_op(1'b0, `SIZE_WORD, 1'b0, 1'b0, 1'b1, 32'h0000_0000, 32'hDDCC_BBAA);
      mem_op(1'b1, `SIZE_HALF, 1'b1, 1'b1, 1'b0, 32'hAABB_CCDD, 32'h0000_DDCC);
      mem_op(1'b0, `SIZE_HALF, 1'b1, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_CCDD);
   endtask
   task hp_defaults;
      hp_op(1'b1, `SIZE_WORD, 32'h1122_3344, steer(32'h1122_3344, `SIZE_WORD, 1'b0, 1'b1));
      hp_op(1'b0, `SIZE_WORD, 32'h1122_3344, steer(32'h1122_3344, `SIZE_WORD, 1'b0, 1'b1));
      hp_op(1'b1, `SIZE_HALF, 32'h1122_3344, steer(32'h1122_3344, `SIZE_HALF, 1'b0, 1'b1));
   endtask
   task hp_regions;
      hp_load(1'b1, 1'b0, 1'b0, 1'b0);
      hp_op(1'b1, `SIZE_WORD, 32'h5566_7788, steer(32'h5566_7788, `SIZE_WORD, 1'b1, 1'b0));
      hp_op(1'b0, `SIZE_WORD, 32'h5566_7788, 32'h5566_7788);
      hp_op(1'b1, `SIZE_HALF, 32'h5566_7788, steer(32'h5566_7788, `SIZE_HALF, 1'b1, 1'b0));
      hp_op(1'b1, `SIZE_BYTE, 32'h5566_7788, 32'h0000_0088);
      hp_load(1'b0, 1'b0, 1'b1, 1'b1);
      hp_op(1'b0, `SIZE_WORD, 32'h99AA_BBCC, steer(32'h99AA_BBCC, `SIZE_WORD, 1'b1, 1'b1));
      hp_op(1'b1, `SIZE_WORD, 32'h99AA_BBCC, 32'h99AA_BBCC);
   endtask
   // Memory region was set to bypass before this reset, so a half swap proves the reload
   task mid_reset;
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      #1;
      check(mem_sys_wdata_o, 32'h0000_0000);
      hp_op(1'b1, `SIZE_WORD, 32'h99AA_BBCC, 32'hBBCC_99AA);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      #200000;
      n_errors++;
      results();
   end
   initial begin
      {reset_n_i, mem_swap_en_i, mem_byte_mode_i, mem_req_i, mem_write_i, mem_addr1_i} = 6'h00;
      {mem_size_i, hp_size_i, mem_dsp_wdata_i, hp_dsp_data_i} = 68'h0_0000_0000_0000_0000;
      {hp_cfg_load_i, hp_mem_byte_swap_i, hp_mem_half_swap_i, hp_reg_byte_swap_i} = 4'h0;
      {hp_reg_half_swap_i, hp_req_i, hp_is_mem_i} = 3'h0;
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      #1;
      check(mem_valid_o, 32'h0000_0000);
      mem_sweep();
      mem_known();
      hp_defaults();
      hp_regions();
      mid_reset();
      results();
   end
endmodule
`default_nettype wire
